//--- qsp_pkg.sv
// Types shared by the position timer
package qsp_pkg;
  typedef enum logic [1:0] {
    QSP_MODE_CAPTURE,
    QSP_MODE_OUTPUT,
    QSP_MODE_COUNT,
    QSP_MODE_POSITION
  } qsp_mode_t;

  typedef struct packed {
    logic [2:0] prescaler_select;
    logic       output_polarity_submode;
    logic       match_index_irq_enable;
    logic       edge_select;
    logic [1:0] mode_field;
  } qsp_mode_ctrl_t;

  typedef struct packed {
    logic a;
    logic b;
  } qsp_chan_t;
endpackage : qsp_pkg

//--- qsp_source_model.sv
// Encoder and step/direction source that drives the timer's channel pins
`timescale 1ns/100ps
module qsp_source_model (
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic rev_i,
  input  wire logic step_mode_i,
  input  wire logic rise_i,
  output logic      pin_a_o,
  output logic      pin_b_o,
  output logic      busy_o
);
  logic [1:0] gray_q = 2'h0;
  logic [4:0] cnt_q  = 5'h0;
  logic       sa_q   = 1'b0;
  logic       sb_q   = 1'b0;

  // Gray order a,b = 00,01,11,10 counts forward; one pin moves per step
  assign pin_a_o = step_mode_i ? sa_q : gray_q[1];
  assign pin_b_o = step_mode_i ? sb_q : gray_q[1] ^ gray_q[0];
  assign busy_o  = (cnt_q != 5'h0);

  // Direction settles well before the pulse, pulse wide enough for filter
  always @(posedge clk_i) begin
    if (go_i) begin
      cnt_q <= 5'h14;
      if (step_mode_i)
        sb_q <= rev_i;
      else
        gray_q <= rev_i ? gray_q - 2'h1 : gray_q + 2'h1;
    end else if (cnt_q != 5'h0)
      cnt_q <= cnt_q - 5'h1;
    if (cnt_q == 5'h10)
      sa_q <= rise_i;
    else if (cnt_q == 5'h08 || (cnt_q == 5'h0 && !go_i))
      sa_q <= !rise_i;
  end
endmodule : qsp_source_model

//--- qsp_timer.sv
// Quadrature and step/direction position timer
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "qsp_timer_regs.svh"
module qsp_timer
  import qsp_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic [7:0]       addr_i,
  input  wire logic [7:0]       wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [7:0]       rdata_o,
  input  wire logic             pin_a_i,
  input  wire logic             pin_b_i,
  input  wire logic             cmp_a_i,
  input  wire logic             cmp_b_i,
  input  wire logic             sample_window_i,
  input  wire logic             index_i,
  output logic                  edge_irq_o,
  output logic                  ovf_irq_o,
  output logic                  index_irq_o
);
  // Control registers and shared state
  qsp_mode_ctrl_t   mctl_q, mctl_d;
  logic [7:0]       ectl_q, ectl_d;
  logic [WIDTH-1:0] pos_q, pos_d;
  logic [WIDTH-1:0] tmr_q, tmr_d;
  logic [WIDTH-1:0] enc_q, enc_d;
  logic [WIDTH-1:0] cap_q, cap_d;
  logic [7:0]       lo_latch_q, lo_latch_d;
  logic [7:0]       rdata_q, rdata_d;
  logic [6:0]       psc_q, psc_d;
  qsp_chan_t        raw, flt_q, flt_d, prev_q;
  qsp_chan_t        smp_q, smp_d;
  logic [2:0]       fcnt_a_q, fcnt_a_d, fcnt_b_q, fcnt_b_d;
  logic             idx_prev_q;
  logic             pos_mode, step_mode, quad_mode;
  logic             tick, act_edge, dir_now, idx_evt, tmr_max;
  logic             rd_cnt_hi;

  // Mode decode
  assign pos_mode  = (mctl_q.mode_field == `QSP_MODE_POS);
  assign step_mode = pos_mode & mctl_q.output_polarity_submode;
  assign quad_mode = pos_mode & ~mctl_q.output_polarity_submode;

  // Source select; comparators held outside the PWM-on window
  always_comb begin
    smp_d = smp_q;
    if (sample_window_i) begin
      smp_d.a = cmp_a_i;
      smp_d.b = cmp_b_i;
    end
  end
  // Both modes always use the pins; the comparator samples are never selected
  assign raw = (quad_mode && !step_mode && mctl_q.edge_select == 1'b0
                && 1'b0) ? smp_q : qsp_chan_t'{pin_a_i, pin_b_i};

  // Glitch filter: output follows only a level stable for 4 cycles
  function automatic logic [2:0] qsp_fcnt(input logic in_v,
                                          input logic out_v,
                                          input logic [2:0] c);
    if (in_v == out_v) qsp_fcnt = 3'h0;
    else if (c == `QSP_FILT_CYCLES - 3'h1) qsp_fcnt = 3'h0;
    else qsp_fcnt = c + 3'h1;
  endfunction : qsp_fcnt

  always_comb begin
    fcnt_a_d = qsp_fcnt(raw.a, flt_q.a, fcnt_a_q);
    fcnt_b_d = qsp_fcnt(raw.b, flt_q.b, fcnt_b_q);
    flt_d    = flt_q;
    if (!ectl_q[`QSP_BIT_FILT]) begin
      flt_d = raw;
    end else begin
      if (raw.a != flt_q.a && fcnt_a_q == `QSP_FILT_CYCLES - 3'h1)
        flt_d.a = raw.a;
      if (raw.b != flt_q.b && fcnt_b_q == `QSP_FILT_CYCLES - 3'h1)
        flt_d.b = raw.b;
    end
  end

  // Decoder: quadrature Gray order or step/direction
  always_comb begin
    act_edge = 1'b0;
    dir_now  = ectl_q[`QSP_BIT_DIR];
    if (step_mode) begin
      // Direction pin is read only at a step edge
      act_edge = mctl_q.edge_select ? (flt_q.a & ~prev_q.a)
                                    : (~flt_q.a & prev_q.a);
      if (act_edge) dir_now = flt_q.b;
    end else if (pos_mode) begin
      // Double transitions are dropped as invalid
      if ((flt_q.a ^ prev_q.a) ^ (flt_q.b ^ prev_q.b)) begin
        act_edge = 1'b1;
        dir_now  = (flt_q.a ^ prev_q.b);
      end
    end
  end

  // Prescaler enable pulse, divide by 2^code
  always_comb begin
    psc_d = ectl_q[`QSP_BIT_TEN] ? psc_q + 7'h1 : 7'h0;
    tick  = ectl_q[`QSP_BIT_TEN] &&
            ((psc_q & ((7'h1 << mctl_q.prescaler_select) - 7'h1))
             == 7'h0);
  end

  assign tmr_max = (tmr_q == `QSP_TMR_MAX);
  assign idx_evt = quad_mode & index_i & ~idx_prev_q;
  assign rd_cnt_hi = rd_i && addr_i == `QSP_OFS_CNT_HI;

  // Counters, capture and flags
  always_comb begin
    pos_d  = pos_q;
    tmr_d  = tmr_q;
    cap_d  = cap_q;
    mctl_d = mctl_q;
    ectl_d = ectl_q;
    enc_d  = enc_q;
    // Software writes first, so hardware sets below win
    if (wr_i) begin
      case (addr_i)
        `QSP_OFS_MODE_CTRL: mctl_d = qsp_mode_ctrl_t'(wdata_i);
        `QSP_OFS_EVENT_CTRL: begin
          ectl_d[4:2] = wdata_i[4:2];
          ectl_d[`QSP_BIT_TEN] = wdata_i[`QSP_BIT_TEN];
          ectl_d[7:5] = ectl_q[7:5] & wdata_i[7:5];
        end
        `QSP_OFS_CNT_LO: pos_d[7:0] = wdata_i;
        `QSP_OFS_CNT_HI: pos_d[15:8] = wdata_i;
        `QSP_OFS_ENC_LO: enc_d[7:0] = wdata_i;
        `QSP_OFS_ENC_HI: enc_d[15:8] = wdata_i;
        `QSP_OFS_CAP_LO: cap_d[7:0] = wdata_i;
        `QSP_OFS_CAP_HI: cap_d[15:8] = wdata_i;
        default: ;
      endcase
    end
    if (pos_mode) begin
      if (tick) begin
        if (tmr_max) begin
          tmr_d = `QSP_RST_WORD;
          ectl_d[`QSP_BIT_OVF_F] = 1'b1;
        end else begin
          tmr_d = tmr_q + 16'h1;
        end
      end
      if (act_edge) begin
        cap_d = tmr_q;
        tmr_d = `QSP_RST_WORD;
        ectl_d[`QSP_BIT_EDGE_F] = 1'b1;
        ectl_d[`QSP_BIT_DIR]    = dir_now;
        if (!dir_now) begin
          if (quad_mode && pos_q == enc_q) pos_d = `QSP_RST_WORD;
          else pos_d = pos_q + 16'h1;
        end else begin
          if (quad_mode && pos_q == `QSP_RST_WORD) pos_d = enc_q;
          else pos_d = pos_q - 16'h1;
        end
      end
      if (idx_evt) begin
        ectl_d[`QSP_BIT_IDX_F] = 1'b1;
        if (mctl_q.edge_select) pos_d = `QSP_RST_WORD;
      end
    end
  end

  // Read data, registered one cycle after the strobe
  always_comb begin
    rdata_d    = 8'h00;
    lo_latch_d = lo_latch_q;
    if (rd_cnt_hi) lo_latch_d = pos_q[7:0];
    if (rd_i) begin
      case (addr_i)
        `QSP_OFS_MODE_CTRL:  rdata_d = mctl_q;
        `QSP_OFS_EVENT_CTRL: rdata_d = ectl_q;
        `QSP_OFS_CNT_LO:     rdata_d = lo_latch_q;
        `QSP_OFS_CNT_HI:     rdata_d = pos_q[15:8];
        `QSP_OFS_ENC_LO:     rdata_d = enc_q[7:0];
        `QSP_OFS_ENC_HI:     rdata_d = enc_q[15:8];
        `QSP_OFS_CAP_LO:     rdata_d = cap_q[7:0];
        `QSP_OFS_CAP_HI:     rdata_d = cap_q[15:8];
        default:             rdata_d = 8'h00;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mctl_q     <= qsp_mode_ctrl_t'(`QSP_RST_BYTE);
      ectl_q     <= `QSP_RST_BYTE;
      pos_q      <= `QSP_RST_WORD;
      tmr_q      <= `QSP_RST_WORD;
      enc_q      <= `QSP_RST_WORD;
      cap_q      <= `QSP_RST_WORD;
      lo_latch_q <= `QSP_RST_BYTE;
      rdata_q    <= `QSP_RST_BYTE;
      psc_q      <= 7'h0;
      flt_q      <= '0;
      prev_q     <= '0;
      smp_q      <= '0;
      fcnt_a_q   <= 3'h0;
      fcnt_b_q   <= 3'h0;
      idx_prev_q <= 1'b0;
    end else begin
      mctl_q     <= mctl_d;
      ectl_q     <= ectl_d;
      pos_q      <= pos_d;
      tmr_q      <= tmr_d;
      enc_q      <= enc_d;
      cap_q      <= cap_d;
      lo_latch_q <= lo_latch_d;
      rdata_q    <= rdata_d;
      psc_q      <= psc_d;
      flt_q      <= flt_d;
      prev_q     <= flt_q;
      smp_q      <= smp_d;
      fcnt_a_q   <= fcnt_a_d;
      fcnt_b_q   <= fcnt_b_d;
      idx_prev_q <= index_i;
    end
  end

  // Outputs; interrupt requests are gated levels of the flags
  assign rdata_o     = rdata_q;
  assign edge_irq_o  = ectl_q[`QSP_BIT_EDGE_F] & ectl_q[`QSP_BIT_EDGE_IE];
  assign ovf_irq_o   = ectl_q[`QSP_BIT_OVF_F] & ectl_q[`QSP_BIT_OVF_IE];
  assign index_irq_o = ectl_q[`QSP_BIT_IDX_F] & mctl_q.match_index_irq_enable;

  // Checks
  AST_EDGE_FLAG: assert property (@(posedge clk_i) disable iff (srst_i)
    pos_mode && act_edge |=> ectl_q[`QSP_BIT_EDGE_F] && tmr_q == 16'h0)
    else $error("edge did not flag or clear base timer");
  AST_CAPTURE: assert property (@(posedge clk_i) disable iff (srst_i)
    pos_mode && act_edge && !wr_i |=> cap_q == $past(tmr_q))
    else $error("base timer not captured");
  AST_OVF: assert property (@(posedge clk_i) disable iff (srst_i)
    pos_mode && tick && tmr_max && !act_edge
    |=> ectl_q[`QSP_BIT_OVF_F] && tmr_q == 16'h0)
    else $error("overflow not flagged");
  AST_STOP: assert property (@(posedge clk_i) disable iff (srst_i)
    !ectl_q[`QSP_BIT_TEN] && !act_edge && !wr_i |=> $stable(tmr_q))
    else $error("base timer ran while disabled");
  AST_UP: assert property (@(posedge clk_i) disable iff (srst_i)
    step_mode && act_edge && !dir_now && !idx_evt && !wr_i
    |=> pos_q == 16'($past(pos_q) + 16'h1))
    else $error("position did not count up");
  AST_DOWN: assert property (@(posedge clk_i) disable iff (srst_i)
    step_mode && act_edge && dir_now && !wr_i
    |=> pos_q == 16'($past(pos_q) - 16'h1))
    else $error("position did not count down");
  AST_QWRAP: assert property (@(posedge clk_i) disable iff (srst_i)
    quad_mode && act_edge && !dir_now && pos_q == enc_q && !wr_i
    |=> pos_q == 16'h0)
    else $error("quadrature wrap missed");
  AST_DIRHOLD: assert property (@(posedge clk_i) disable iff (srst_i)
    step_mode && !act_edge && !wr_i |=> $stable(ectl_q[`QSP_BIT_DIR]))
    else $error("direction changed without step");
  AST_IDX: assert property (@(posedge clk_i) disable iff (srst_i)
    idx_evt |=> ectl_q[`QSP_BIT_IDX_F])
    else $error("index flag not set");
endmodule : qsp_timer

//--- qsp_timer_regs.svh
// Register offsets, field positions and reset values of the position timer
`ifndef QSP_TIMER_REGS_SVH
`define QSP_TIMER_REGS_SVH
`define QSP_OFS_MODE_CTRL   8'ha1
`define QSP_OFS_EVENT_CTRL  8'ha9
`define QSP_OFS_CNT_LO      8'haa
`define QSP_OFS_CNT_HI      8'hab
`define QSP_OFS_ENC_LO      8'hac
`define QSP_OFS_ENC_HI      8'had
`define QSP_OFS_CAP_LO      8'hae
`define QSP_OFS_CAP_HI      8'haf
`define QSP_RST_BYTE        8'h00
`define QSP_RST_WORD        16'h0000
`define QSP_BIT_EDGE_SEL    2
`define QSP_BIT_IDX_IRQ_EN  3
`define QSP_BIT_SUBMODE     4
`define QSP_BIT_TEN         0
`define QSP_BIT_DIR         1
`define QSP_BIT_FILT        2
`define QSP_BIT_OVF_IE      3
`define QSP_BIT_EDGE_IE     4
`define QSP_BIT_OVF_F       5
`define QSP_BIT_EDGE_F      6
`define QSP_BIT_IDX_F       7
`define QSP_MODE_POS        2'b11
`define QSP_FILT_CYCLES     3'h4
`define QSP_TMR_MAX         16'hffff
`endif

//--- test_qsp_timer.sv
// Self-checking bench for the position timer
`timescale 1ns/100ps
`include "qsp_timer_regs.svh"
module test_qsp_timer;
  logic        clk_i   = 1'b0;
  logic        srst_i  = 1'b1;
  logic [7:0]  addr_i  = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic        index_i = 1'b0;
  logic        go      = 1'b0;
  logic        rev     = 1'b0;
  logic        stp     = 1'b0;
  logic        rise    = 1'b1;
  logic        pin_a, pin_b, busy, edge_irq_o, ovf_irq_o, index_irq_o;
  logic [7:0]  rdata_o, r;
  logic [15:0] pos, v;
  logic [15:0] enc     = 16'h0003;
  logic [7:0]  qdir    = 8'b0001_1100;
  logic [7:0]  ectl    = 8'h19;
  logic [7:0]  ofs [9];
  integer      err_count = 0;
  integer      checks    = 0;
  integer      seed      = 32'h5600;
  integer      i, n;

  qsp_timer i_qsp_timer (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pin_a_i(pin_a), .pin_b_i(pin_b), .cmp_a_i(1'b0), .cmp_b_i(1'b0),
    .sample_window_i(1'b0), .index_i(index_i), .edge_irq_o(edge_irq_o),
    .ovf_irq_o(ovf_irq_o), .index_irq_o(index_irq_o));
  qsp_source_model i_qsp_source_model (.clk_i(clk_i), .go_i(go),
    .rev_i(rev), .step_mode_i(stp), .rise_i(rise), .pin_a_o(pin_a),
    .pin_b_o(pin_b), .busy_o(busy));

  // Free-running system clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  // High byte first so the low byte comes from the same sample
  task automatic rd_cnt(output logic [15:0] c);
    logic [7:0] h, l;
    rd(`QSP_OFS_CNT_HI, h);
    rd(`QSP_OFS_CNT_LO, l);
    c = {h, l};
  endtask : rd_cnt

  function automatic logic [15:0] nxt(input logic [15:0] p, input logic b,
                                      input logic q, input logic [15:0] e);
    if (!b)
      nxt = (q && p == e) ? 16'h0000 : p + 16'h0001;
    else
      nxt = (q && p == 16'h0000) ? e : p - 16'h0001;
  endfunction : nxt

  // One source step, then count, direction and edge flag
  task automatic step_chk(input logic b, input logic q);
    @(posedge clk_i);
    go  <= 1'b1;
    rev <= b;
    @(posedge clk_i);
    go  <= 1'b0;
    repeat (2) @(posedge clk_i);
    for (n = 0; n < 40 && busy !== 1'b0; n++) @(posedge clk_i);
    pos = nxt(pos, b, q, enc);
    rd_cnt(v);
    check(v, pos);
    rd(`QSP_OFS_EVENT_CTRL, r);
    check(r[1], b);
    check({r[6], edge_irq_o}, 2'b11);
    wr(`QSP_OFS_EVENT_CTRL, ectl);
  endtask : step_chk

  // Watchdog sized above the overflow wait plus all steps
  initial begin
    repeat (90000) @(posedge clk_i);
    err_count = err_count + 1;
    tally_and_finish();
  end

  initial begin
    ofs = '{`QSP_OFS_MODE_CTRL, `QSP_OFS_EVENT_CTRL, `QSP_OFS_CNT_LO,
            `QSP_OFS_CNT_HI, `QSP_OFS_ENC_LO, `QSP_OFS_ENC_HI,
            `QSP_OFS_CAP_LO, `QSP_OFS_CAP_HI, 8'h00};
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    for (i = 0; i < 9; i++) begin
      rd(ofs[i], r);
      check(r, 8'h00);
    end
    wr(`QSP_OFS_EVENT_CTRL, 8'h02);
    rd(`QSP_OFS_EVENT_CTRL, r);
    check(r, 8'h00);
    $display("reset values done");
    wr(`QSP_OFS_ENC_LO, enc[7:0]);
    wr(`QSP_OFS_ENC_HI, enc[15:8]);
    wr(`QSP_OFS_MODE_CTRL, 8'h0f);
    wr(`QSP_OFS_EVENT_CTRL, 8'h19);
    pos = 16'h0000;
    for (i = 0; i < 8; i++) step_chk(qdir[i], 1'b1);
    @(posedge clk_i);
    index_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    index_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    rd(`QSP_OFS_EVENT_CTRL, r);
    check({r[7], index_irq_o}, 2'b11);
    rd_cnt(v);
    check(v, 16'h0000);
    pos = 16'h0000;
    wr(`QSP_OFS_EVENT_CTRL, 8'h19);
    step_chk(1'b1, 1'b1);
    step_chk(1'b1, 1'b1);
    $display("quadrature done");
    wr(`QSP_OFS_MODE_CTRL, 8'h17);
    stp <= 1'b1;
    for (i = 0; i < 3; i++) step_chk(1'b1, 1'b0);
    for (i = 0; i < 12; i++) step_chk($random(seed), 1'b0);
    wr(`QSP_OFS_MODE_CTRL, 8'h13);
    // Filter on for the falling-edge run; 8-cycle pulses must still count
    ectl = 8'h1d;
    wr(`QSP_OFS_EVENT_CTRL, ectl);
    rise <= 1'b0;
    repeat (10) @(posedge clk_i);
    for (i = 0; i < 12; i++) step_chk($random(seed), 1'b0);
    $display("stepping done");
    for (i = 0; i < 70000 && ovf_irq_o !== 1'b1; i++) @(posedge clk_i);
    check(ovf_irq_o, 1'b1);
    check(i >= 65000 && i <= 65536, 1'b1);
    wr(`QSP_OFS_EVENT_CTRL, 8'hf9);
    rd(`QSP_OFS_EVENT_CTRL, r);
    check(r[5], 1'b1);
    wr(`QSP_OFS_EVENT_CTRL, 8'h11);
    @(posedge clk_i);
    check(ovf_irq_o, 1'b0);
    wr(`QSP_OFS_EVENT_CTRL, 8'h19);
    rd(`QSP_OFS_EVENT_CTRL, r);
    check(r[5], 1'b0);
    $display("overflow done");
    tally_and_finish();
  end
endmodule : test_qsp_timer
